// ===== core/fsl_link.sv
// fast serial link engine: framing, flow control, contention, routing
// Functional notes
// - data out changes only on serial clock edges; link disable forces it idle at once
// - outbound frame starts with low start bit
// - no outbound start during inbound reception
// - start, eight data LSB first, channel
// - outbound channel bit marks source channel
// - clear drops on the start bit edge
// - clear stays low until byte accepted
// - route inbound by channel, fall back
// - link disabled unless a channel enabled
// - simultaneous start: device withdraws, receives
// - mode hold stops new outbound frames, run releases
// - serial mode only when config enables
// - link always on second channel pins
// - half duplex, one direction at once
`timescale 1ns/1ps
module fsl_link #(
    parameter int unsigned DATA_W = fsl_pkg::FSL_DATA_W,
    parameter int unsigned FIFO_D = fsl_pkg::FSL_FIFO_D
) (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    // configuration memory enables
    input  wire logic              i_cfg_en_a,
    input  wire logic              i_cfg_en_b,
    // mode command from host side
    input  wire logic              i_mode_wr,
    input  wire logic [7:0]        i_mode_val,
    // outbound bytes from channel a
    input  wire logic              i_tx_a_valid,
    input  wire logic [DATA_W-1:0] i_tx_a_data,
    output logic                   o_tx_a_ready,
    // outbound bytes from channel b
    input  wire logic              i_tx_b_valid,
    input  wire logic [DATA_W-1:0] i_tx_b_data,
    output logic                   o_tx_b_ready,
    // inbound bytes to channels
    output logic                   o_rx_a_valid,
    output logic                   o_rx_b_valid,
    output logic      [DATA_W-1:0] o_rx_data,
    input  wire logic              i_rx_a_ready,
    input  wire logic              i_rx_b_ready,
    // serial link pins, on channel b pins
    input  wire logic              i_serial_clock_in,
    input  wire logic              i_serial_data_in,
    output logic                   o_serial_data_out,
    output logic                   o_clear_to_send_out,
    output logic                   o_link_active
);
    import fsl_pkg::*;
    // ------------------------------------------------------------
    // pin synchronisers and clock edge detect
    // ------------------------------------------------------------
    logic sclk_s;
    logic sdi_s;
    logic sclk_q;
    fsl_sync #(.RST_VAL(1'b0)) u_sync_clk (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_serial_clock_in),
        .o_sync    (sclk_s)
    );
    fsl_sync #(.RST_VAL(1'b1)) u_sync_dat (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_serial_data_in),
        .o_sync    (sdi_s)
    );
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
        end
    end
    // apart from link disable, data out never moves without a far-end rising edge; clear follows the byte handshake
    wire rise = sclk_s && !sclk_q;

    // ------------------------------------------------------------
    // enable and hold-in-reset
    // ------------------------------------------------------------
    logic hold_q;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_q <= 1'b0;
        end else if (i_mode_wr && i_mode_val == FSL_MODE_HOLD) begin
            hold_q <= 1'b1;
        end else if (i_mode_wr && i_mode_val == FSL_MODE_RUN) begin
            hold_q <= 1'b0;
        end
    end
    wire link_en = i_cfg_en_a || i_cfg_en_b;

    // ------------------------------------------------------------
    // outbound fifo: one word is channel bit plus byte
    // ------------------------------------------------------------
    localparam int unsigned FW = DATA_W + 1;
    wire              pick_a   = i_tx_a_valid && i_cfg_en_a;
    wire              pick_b   = !pick_a && i_tx_b_valid && i_cfg_en_b;
    wire              tf_valid = link_en && (pick_a || pick_b);
    wire [FW-1:0]     tf_in    = pick_a ? {FSL_CHAN_A, i_tx_a_data}
                                        : {FSL_CHAN_B, i_tx_b_data};
    logic             tf_ready;
    logic             tf_ovalid;
    logic [FW-1:0]    tf_out;
    logic             tf_pop;
    assign o_tx_a_ready = tf_ready && link_en && i_cfg_en_a;
    assign o_tx_b_ready = tf_ready && link_en && i_cfg_en_b && !pick_a;
    fsl_fifo #(.WIDTH(FW), .DEPTH(FIFO_D)) u_tx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_valid   (tf_valid),
        .i_data    (tf_in),
        .o_ready   (tf_ready),
        .o_valid   (tf_ovalid),
        .o_data    (tf_out),
        .i_ready   (tf_pop)
    );

    // ------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------
    fsl_state_e        st_q, st_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [DATA_W:0]   sh_q, sh_d;
    logic              sdo_q, sdo_d;
    logic              cts_q, cts_d;
    logic              rxv_q, rxv_d;
    logic              rsel_q, rsel_d;
    logic [DATA_W-1:0] rxd_q, rxd_d;
    logic              rxa_q;
    logic              rxb_q;
    logic              act_q;
    wire               rx_take = rxv_q && (rsel_q ? i_rx_b_ready : i_rx_a_ready);
    // a held link still accepts host bytes into the fifo but never starts a frame
    wire               can_tx  = link_en && !hold_q && tf_ovalid;
    // the channel bit, last of the inbound frame, picks a channel, enable decides the fallback
    wire               destination_channel_bit    = sh_q[DATA_W];
    wire               route_b = destination_channel_bit ? i_cfg_en_b : !i_cfg_en_a;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        sdo_d  = sdo_q;
        cts_d  = cts_q;
        rxv_d  = rxv_q && !rx_take;
        rsel_d = rsel_q;
        rxd_d  = rxd_q;
        tf_pop = 1'b0;
        case (st_q)
            FSL_IDLE: begin
                cts_d = link_en && !rxv_q;
                sdo_d = FSL_IDLE_LVL;
                if (rise && link_en) begin
                    // far start wins over ours on the same edge
                    if (sdi_s == FSL_START_LVL && cts_q) begin
                        cts_d = 1'b0;
                        cnt_d = FSL_BIT_ZERO;
                        st_d  = FSL_RX_DAT;
                    end else if (can_tx) begin
                        sdo_d  = FSL_START_LVL;
                        // clear drops while we talk so the far end cannot start too
                        cts_d  = 1'b0;
                        sh_d   = tf_out;
                        cnt_d  = FSL_BIT_ZERO;
                        tf_pop = 1'b1;
                        st_d   = FSL_TX_DAT;
                    end
                end
            end
            FSL_RX_DAT: begin
                if (rise) begin
                    sh_d = {sdi_s, sh_q[DATA_W:1]};
                    cnt_d = cnt_q + FSL_BIT_ONE;
                    if (cnt_q == FSL_LAST_DATA) begin
                        st_d = FSL_RX_CH;
                    end
                end
            end
            FSL_RX_CH: begin
                if (rise) begin
                    sh_d = {sdi_s, sh_q[DATA_W:1]};
                    st_d = FSL_RX_WT;
                end
            end
            FSL_RX_WT: begin
                if (!rxv_q) begin
                    rxv_d  = 1'b1;
                    rsel_d = route_b;
                    rxd_d  = sh_q[DATA_W-1:0];
                    st_d   = FSL_IDLE;
                end
            end
            FSL_TX_DAT: begin
                // a stalled far clock simply freezes this shift
                if (rise) begin
                    sdo_d = sh_q[0];
                    sh_d  = {1'b0, sh_q[DATA_W:1]};
                    cnt_d = cnt_q + FSL_BIT_ONE;
                    if (cnt_q == FSL_LAST_DATA) begin
                        st_d = FSL_TX_CH;
                    end
                end
            end
            FSL_TX_CH: begin
                if (rise) begin
                    sdo_d = sh_q[0];
                    st_d  = FSL_TX_END;
                end
            end
            FSL_TX_END: begin
                if (rise) begin
                    sdo_d = FSL_IDLE_LVL;
                    st_d  = FSL_IDLE;
                end
            end
            default: begin
                st_d = FSL_IDLE;
            end
        endcase
        if (!link_en) begin
            st_d  = FSL_IDLE;
            sdo_d = FSL_IDLE_LVL;
            cts_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q   <= FSL_IDLE;
            cnt_q  <= '0;
            sh_q   <= '0;
            sdo_q  <= FSL_IDLE_LVL;
            cts_q  <= 1'b0;
            rxv_q  <= 1'b0;
            rsel_q <= 1'b0;
            rxd_q  <= '0;
            rxa_q  <= 1'b0;
            rxb_q  <= 1'b0;
            act_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            sdo_q  <= sdo_d;
            cts_q  <= cts_d;
            rxv_q  <= rxv_d;
            rsel_q <= rsel_d;
            rxd_q  <= rxd_d;
            rxa_q  <= rxv_d && !rsel_d;
            rxb_q  <= rxv_d && rsel_d;
            act_q  <= (st_d != FSL_IDLE);
        end
    end

    assign o_serial_data_out   = sdo_q;
    assign o_clear_to_send_out = cts_q;
    assign o_rx_a_valid        = rxa_q;
    assign o_rx_b_valid        = rxb_q;
    assign o_rx_data           = rxd_q;
    assign o_link_active       = act_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    wire rx_st = (st_q == FSL_RX_DAT) || (st_q == FSL_RX_CH) || (st_q == FSL_RX_WT);
    wire tx_st = (st_q == FSL_TX_DAT) || (st_q == FSL_TX_CH) || (st_q == FSL_TX_END);

    sdo_no_edge_a: assert property (!rise |=> $stable(sdo_q))
        else $error("data out moved without clock edge");
    tx_start_low_a: assert property (
        (st_q == FSL_IDLE) ##1 (st_q == FSL_TX_DAT) |-> sdo_q == FSL_START_LVL)
        else $error("frame did not begin with low start bit");
    no_tx_in_rx_a: assert property (rx_st |=> !tx_st)
        else $error("outbound frame during reception");
    tx_length_a: assert property (
        st_q == FSL_TX_CH |-> cnt_q == FSL_LAST_DATA + FSL_BIT_ONE)
        else $error("data phase did not last eight bits");
    tx_idle_end_a: assert property (
        (st_q == FSL_TX_END && rise) |=> sdo_q == FSL_IDLE_LVL && st_q == FSL_IDLE)
        else $error("frame did not return to idle after channel bit");
    cts_drop_a: assert property (
        (st_q == FSL_IDLE) ##1 (st_q == FSL_RX_DAT) |-> !cts_q && $past(rise))
        else $error("clear to send did not drop at start bit");
    cts_low_rx_a: assert property ((rx_st || tx_st) |-> !cts_q)
        else $error("clear to send high during frame");
    rx_route_a: assert property (
        (st_q == FSL_RX_WT && !rxv_q) |=> rxv_q
        && rsel_q == $past((sh_q[DATA_W] && i_cfg_en_b) || !i_cfg_en_a))
        else $error("inbound byte misrouted");
    rx_one_hot_a: assert property (!(o_rx_a_valid && o_rx_b_valid))
        else $error("inbound byte offered to both channels");
    link_off_a: assert property (!link_en |=> !cts_q && sdo_q)
        else $error("link active while disabled");
    tx_backoff_a: assert property (
        (st_q == FSL_IDLE && rise && link_en && cts_q && !sdi_s) |=> st_q == FSL_RX_DAT)
        else $error("device did not back off on contention");
    hold_no_tx_a: assert property (hold_q && st_q == FSL_IDLE |=> st_q != FSL_TX_DAT)
        else $error("transmit while held in reset");

    rx_cov: cover property (st_q == FSL_RX_WT ##1 rxv_q);
    tx_cov: cover property (st_q == FSL_TX_END ##1 st_q == FSL_IDLE);
    fb_cov: cover property (st_q == FSL_RX_WT && !rxv_q && destination_channel_bit != route_b);
    full_cov: cover property (!tf_ready);
endmodule

// ===== core/fsl_pkg.sv
// package: constants and types for the opto-isolated fast serial link
package fsl_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int unsigned FSL_DATA_W    = 8;
    localparam int unsigned FSL_FIFO_D    = 8;
    localparam logic [3:0]  FSL_LAST_DATA = 4'h7;
    localparam logic [3:0]  FSL_BIT_ZERO  = 4'h0;
    localparam logic [3:0]  FSL_BIT_ONE   = 4'h1;
    localparam logic        FSL_START_LVL = 1'b0;
    localparam logic        FSL_IDLE_LVL  = 1'b1;
    localparam logic        FSL_CHAN_A    = 1'b0;
    localparam logic        FSL_CHAN_B    = 1'b1;
    // ------------------------------------------------------------
    // mode command values
    // ------------------------------------------------------------
    localparam logic [7:0]  FSL_MODE_HOLD = 8'h10;
    localparam logic [7:0]  FSL_MODE_RUN  = 8'h00;
    // ------------------------------------------------------------
    // link state machine, gray along the receive path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSL_IDLE   = 3'b000,
        FSL_RX_DAT = 3'b001,
        FSL_RX_CH  = 3'b011,
        FSL_RX_WT  = 3'b010,
        FSL_TX_DAT = 3'b110,
        FSL_TX_CH  = 3'b111,
        FSL_TX_END = 3'b101
    } fsl_state_e;
endpackage

// ===== core/fsl_sync.sv
// two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module fsl_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // data
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ===== core/fsl_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module fsl_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    // fill side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    // drain side
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;
    // the count is one bit wider than the pointers, so full is compared at that width
    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rd_q];
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ===== verification/fsl_far_end.sv
// far-end model: clocks the link, sends inbound frames and captures outbound ones
`timescale 1ns/1ps
module fsl_far_end (
    // link from the device
    input  wire logic i_serial_data_out,
    input  wire logic i_clear_to_send_out,
    // link to the device
    output logic      o_serial_clock_in,
    output logic      o_serial_data_in
);
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    // clock stands low between frames; data line released to its pull-up level
    initial begin
        o_serial_clock_in = 1'b0;
        o_serial_data_in  = 1'b1;
    end
    // a 790 ns pulse, 400 ns high and 390 ns low, callers add 10 ns per bit; data only moves while the clock is low
    task automatic pulse();
        o_serial_clock_in = 1'b1;
        #400;
        o_serial_clock_in = 1'b0;
        #390;
    endtask
    // ------------------------------------------------------------
    // frames
    // ------------------------------------------------------------
    // bit 0 start, 8:1 data, 9 channel, 10 idle after the frame
    task automatic recv_frame(input int stall_ns, output logic [10:0] bits);
        for (int i = 0; i < 11; i++) begin
            pulse();
            if (i == 0) #(stall_ns);
            bits[i] = i_serial_data_out;
            #10;
        end
    endtask
    // a far end that finds clear low gives up, so a hung device shows as ok low
    task automatic send_frame(input logic [7:0] d, input logic ch,
                              output logic ok, output logic cts0, output logic sdo0);
        logic [9:0] bits;
        bits = {ch, d, 1'b0};
        ok   = 1'b0;
        cts0 = 1'b1;
        sdo0 = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            if (i_clear_to_send_out === 1'b1) ok = 1'b1;
            else #100;
        end
        if (ok) begin
            for (int i = 0; i < 10; i++) begin
                o_serial_data_in = bits[i];
                pulse();
                if (i == 0) begin
                    cts0 = i_clear_to_send_out;
                    sdo0 = i_serial_data_out;
                end
                #10;
            end
            o_serial_data_in = 1'b1;
        end
    endtask
endmodule

// ===== verification/tb_top.sv
// testbench for the fast serial link engine
`timescale 1ns/1ps
module tb_top;
    import fsl_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       sys_clk = 1'b0, rst = 1'b1, en_a = 1'b1, en_b = 1'b1, mode_wr = 1'b0;
    logic [7:0] mode_val = 8'h00, tx_a_data = 8'h00, tx_b_data = 8'h00, rx_data;
    logic       tx_a_valid = 1'b0, tx_b_valid = 1'b0, tx_a_ready, tx_b_ready;
    logic       rx_a_valid, rx_b_valid, rx_a_ready = 1'b0, rx_b_ready = 1'b0;
    logic       sclk, sdi, sdo, cts, active;
    int         num_errors = 0, checked = 0;
    always #50 sys_clk = ~sys_clk;
    fsl_link i_dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_cfg_en_a(en_a), .i_cfg_en_b(en_b),
        .i_mode_wr(mode_wr), .i_mode_val(mode_val),
        .i_tx_a_valid(tx_a_valid), .i_tx_a_data(tx_a_data), .o_tx_a_ready(tx_a_ready),
        .i_tx_b_valid(tx_b_valid), .i_tx_b_data(tx_b_data), .o_tx_b_ready(tx_b_ready),
        .o_rx_a_valid(rx_a_valid), .o_rx_b_valid(rx_b_valid), .o_rx_data(rx_data),
        .i_rx_a_ready(rx_a_ready), .i_rx_b_ready(rx_b_ready),
        .i_serial_clock_in(sclk), .i_serial_data_in(sdi),
        .o_serial_data_out(sdo), .o_clear_to_send_out(cts), .o_link_active(active)
    );
    fsl_far_end i_far (
        .i_serial_data_out(sdo), .i_clear_to_send_out(cts),
        .o_serial_clock_in(sclk), .o_serial_data_in(sdi)
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic timed_out();
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
        num_errors++;
        stop_test();
    endtask
    function automatic logic [10:0] frame(input logic [7:0] d, input logic ch);
        return {1'b1, ch, d, 1'b0};
    endfunction
    task automatic push(input logic ch, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        if (ch) {tx_b_valid, tx_b_data} = {1'b1, d};
        else {tx_a_valid, tx_a_data} = {1'b1, d};
        while ((ch ? tx_b_ready : tx_a_ready) !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 50) timed_out();
        @(negedge sys_clk);
        {tx_a_valid, tx_b_valid} = 2'b00;
    endtask
    // waits for the byte, checks routing, accepts it, then expects clear back high
    task automatic take_rx(input logic ch, input logic [7:0] d);
        int n;
        n = 0;
        while ((ch ? rx_b_valid : rx_a_valid) !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 50) timed_out();
        chk({1'b0, rx_b_valid, rx_a_valid, rx_data}, {1'b0, ch, ~ch, d});
        chk({10'h000, cts}, 11'h000);
        {rx_a_ready, rx_b_ready} = {~ch, ch};
        @(negedge sys_clk);
        {rx_a_ready, rx_b_ready} = 2'b00;
        n = 0;
        while (cts !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk({10'h000, cts}, 11'h001);
    endtask
    task automatic set_mode(input logic [7:0] v);
        @(negedge sys_clk);
        {mode_wr, mode_val} = {1'b1, v};
        @(negedge sys_clk);
        mode_wr = 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_tx();
        logic [10:0] bits;
        push(1'b0, 8'hA5);
        push(1'b1, 8'h3C);
        chk({9'h000, active, sdo}, 11'h001);
        i_far.recv_frame(0, bits);
        chk(bits, frame(8'hA5, FSL_CHAN_A));
        i_far.recv_frame(0, bits);
        chk(bits, frame(8'h3C, FSL_CHAN_B));
        push(1'b1, 8'h81);
        fork
            i_far.recv_frame(5000, bits);
            begin
                #2000;
                chk({9'h000, active, sdo}, 11'h002);
            end
        join
        chk(bits, frame(8'h81, FSL_CHAN_B));
        $display("test tx done");
    endtask
    task automatic t_rx();
        logic       ok, c0, s0;
        logic [3:0] ea = 4'b1101, eb = 4'b1011, dst = 4'b0101, to = 4'b0011;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            {en_a, en_b} = {ea[i], eb[i]};
            repeat (3) @(negedge sys_clk);
            i_far.send_frame(8'h5A ^ 8'(i), dst[i], ok, c0, s0);
            chk({8'h00, ok, c0, s0}, 11'h005);
            take_rx(to[i], 8'h5A ^ 8'(i));
        end
        $display("test rx done");
    endtask
    task automatic t_contend();
        logic        ok, c0, s0;
        logic [10:0] bits;
        push(1'b0, 8'h77);
        i_far.send_frame(8'h99, 1'b1, ok, c0, s0);
        chk({8'h00, ok, c0, s0}, 11'h005);
        take_rx(1'b1, 8'h99);
        i_far.recv_frame(0, bits);
        chk(bits, frame(8'h77, FSL_CHAN_A));
        $display("test contention done");
    endtask
    task automatic t_hold();
        logic [10:0] bits;
        set_mode(FSL_MODE_HOLD);
        push(1'b0, 8'h42);
        i_far.recv_frame(0, bits);
        chk(bits, 11'h7FF);
        set_mode(FSL_MODE_RUN);
        i_far.recv_frame(0, bits);
        chk(bits, frame(8'h42, FSL_CHAN_A));
        $display("test hold done");
    endtask
    task automatic t_off();
        logic ok, c0, s0;
        @(negedge sys_clk);
        {en_a, en_b} = 2'b00;
        repeat (5) @(negedge sys_clk);
        chk({8'h00, tx_a_ready, tx_b_ready, cts}, 11'h000);
        i_far.send_frame(8'h11, 1'b0, ok, c0, s0);
        chk({10'h000, ok}, 11'h000);
        @(negedge sys_clk);
        {en_a, en_b} = 2'b11;
        repeat (5) @(negedge sys_clk);
        chk({8'h00, rx_a_valid, rx_b_valid, cts}, 11'h001);
        $display("test disable done");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_tx();
        t_rx();
        t_contend();
        t_hold();
        t_off();
        stop_test();
    end
endmodule
